// ===== hw/sbmr_consts.vh
// constants for the shunt and bus measurement result block
`ifndef SBMR_CONSTS_VH
`define SBMR_CONSTS_VH
// ============================================
// register pointers
`define SBMR_PTR_CONFIG 8'h00
`define SBMR_PTR_SHUNT 8'h01
`define SBMR_PTR_BUS 8'h02
`define SBMR_PTR_POWER 8'h03
`define SBMR_PTR_CURRENT 8'h04
// ============================================
// configuration fields and reset value
`define SBMR_CFG_RESET 16'h399f
`define SBMR_CFG_RST_BIT 15
`define SBMR_CFG_RANGE_BIT 13
`define SBMR_CFG_GAIN_HI 12
`define SBMR_CFG_GAIN_LO 11
`define SBMR_CFG_BUSCV_HI 10
`define SBMR_CFG_BUSCV_LO 7
`define SBMR_CFG_SHCV_HI 6
`define SBMR_CFG_SHCV_LO 3
`define SBMR_CFG_MODE_HI 2
`define SBMR_CFG_MODE_LO 0
`define SBMR_CFG_WMASK 16'hbfff
// ============================================
// mode codes
`define SBMR_MODE_PDOWN 3'h0
`define SBMR_MODE_OFF 3'h4
// ============================================
// result layout
`define SBMR_RES_RESET 16'h0000
`define SBMR_BUS_READY_BIT 1
`define SBMR_BUS_OVF_BIT 0
`define SBMR_BUS_FS_32V 13'h1f40
`define SBMR_BUS_FS_16V 13'h0fa0
`define SBMR_SHUNT_FS_UNITY 17'h00fa0
// ============================================
// timing, in microseconds and at the clock rate
`define SBMR_CLK_MHZ 125
`define SBMR_WRITE_DELAY_US 4
`define SBMR_T9_US 84
`define SBMR_T10_US 148
`define SBMR_T11_US 276
`define SBMR_T12_US 532
`define SBMR_TAVG2_US 1060
`define SBMR_TAVG4_US 2130
`define SBMR_TAVG8_US 4260
`define SBMR_TAVG16_US 8510
`define SBMR_TAVG32_US 17020
`define SBMR_TAVG64_US 34050
`define SBMR_TAVG128_US 68100
`endif

// ===== hw/sbmr_shunt_fmt.v
// shunt result formatter: gain-dependent saturation and sign extension
`timescale 1ns/1ns
`default_nettype none
`include "sbmr_consts.vh"
module sbmr_shunt_fmt (
  // raw reading in 10 uV steps, signed
  input wire [16:0] sample,
  // gain select, 0 = unity .. 3 = divide by 8
  input wire [1:0] gain,
  // formatted word
  output reg [15:0] word
);
  reg [16:0] limit;
  reg [16:0] neg_limit;

  // clamp to plus or minus full scale of the gain, lsb stays 10 uV
  always @* begin
    limit = `SBMR_SHUNT_FS_UNITY << gain;
    neg_limit = (~limit) + 17'h00001;
    if (!sample[16] && (sample > limit))
      word = limit[15:0];
    else if (sample[16] && (sample < neg_limit))
      word = neg_limit[15:0];
    else
      word = sample[15:0]; // upper bits are copies of the sign
  end
endmodule // sbmr_shunt_fmt
`default_nettype wire

// ===== hw/sbmr_timer.v
// down counter that marks the end of a conversion or a write delay
`timescale 1ns/1ns
`default_nettype none
module sbmr_timer (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // control
  input wire load,
  input wire [23:0] load_value,
  // status
  output reg expired
);
  reg [23:0] count_reg;
  reg running_reg;

  // count down from the load value, pulse once at zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 24'h000000;
      running_reg <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        count_reg <= load_value;
        running_reg <= 1'b1;
      end else if (running_reg) begin
        if (count_reg <= 24'h000001) begin
          running_reg <= 1'b0;
          expired <= 1'b1;
        end else begin
          count_reg <= count_reg - 24'h000001;
        end
      end
    end
  end
endmodule // sbmr_timer
`default_nettype wire

// ===== hw/sbmr_top.v
// measurement control and result formatting for the shunt and bus monitor
`timescale 1ns/1ns
`default_nettype none
`include "sbmr_consts.vh"
module sbmr_top #(
  parameter CYCLES_PER_US = `SBMR_CLK_MHZ
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // register port from the serial slave
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [15:0] reg_wr_data,
  input wire reg_rd,
  output reg [15:0] reg_rd_data,
  // converter samples, taken when a conversion ends
  input wire [16:0] shunt_sample,
  input wire [13:0] bus_sample,
  // current and power engine
  input wire [15:0] power_value,
  input wire [15:0] current_value,
  input wire math_done,
  input wire math_overflow,
  output reg math_start,
  // analog front end controls
  output reg [1:0] shunt_gain_stage,
  output reg bus_range_select,
  output reg converter_busy
);
  // ============================================
  // state codes
  localparam ST_IDLE = 2'd0;
  localparam ST_SHUNT = 2'd1;
  localparam ST_BUS = 2'd2;
  localparam ST_MATH = 2'd3;

  localparam integer WRITE_DELAY_INT = `SBMR_WRITE_DELAY_US * CYCLES_PER_US;
  localparam [23:0] WRITE_DELAY_CYC = WRITE_DELAY_INT[23:0];

  // conversion time in cycles for a four-bit conversion setting
  function [23:0] conv_cycles;
    input [3:0] setting;
    reg [31:0] us;
    begin
      us = 32'd0;
      if (!setting[3]) begin
        case (setting[1:0]) // third bit ignored
          2'b00: us = `SBMR_T9_US;
          2'b01: us = `SBMR_T10_US;
          2'b10: us = `SBMR_T11_US;
          default: us = `SBMR_T12_US;
        endcase
      end else begin
        case (setting[2:0])
          3'd0: us = `SBMR_T12_US;
          3'd1: us = `SBMR_TAVG2_US;
          3'd2: us = `SBMR_TAVG4_US;
          3'd3: us = `SBMR_TAVG8_US;
          3'd4: us = `SBMR_TAVG16_US;
          3'd5: us = `SBMR_TAVG32_US;
          3'd6: us = `SBMR_TAVG64_US;
          default: us = `SBMR_TAVG128_US;
        endcase
      end
      conv_cycles = us[23:0] * CYCLES_PER_US[23:0];
    end
  endfunction

  // true for a mode code that runs the converter
  function mode_active;
    input [2:0] mode;
    begin
      mode_active = (mode != `SBMR_MODE_PDOWN) && (mode != `SBMR_MODE_OFF);
    end
  endfunction

  // ============================================
  // registers and wires
  reg [15:0] config_reg;
  reg [15:0] shunt_result_reg;
  reg [12:0] bus_value_reg;
  reg ready_reg;
  reg overflow_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg pend_reg;
  reg [15:0] pend_data_reg;
  reg [7:0] pend_addr_reg;
  reg restart_reg;
  reg timer_load;
  reg [23:0] timer_value;
  wire delay_done;
  wire conv_done;
  wire [15:0] shunt_word;
  wire [2:0] mode;
  wire [3:0] bus_setting;
  wire [3:0] shunt_setting;
  wire [12:0] bus_fs;
  wire [12:0] bus_clamped;
  wire apply_write;
  wire apply_config;
  wire [15:0] bus_word;
  reg boot_reg;
  wire launch;

  // configuration fields
  assign mode = config_reg[`SBMR_CFG_MODE_HI:`SBMR_CFG_MODE_LO];
  assign bus_setting = config_reg[`SBMR_CFG_BUSCV_HI:`SBMR_CFG_BUSCV_LO];
  assign shunt_setting = config_reg[`SBMR_CFG_SHCV_HI:`SBMR_CFG_SHCV_LO];
  assign apply_write = pend_reg && delay_done;
  assign apply_config = apply_write && (pend_addr_reg == `SBMR_PTR_CONFIG);
  assign launch = restart_reg || boot_reg; // reset or config write starts a run

  // ============================================
  // write delay: a write lands after the settle time
  sbmr_timer u_write_delay (
    .clk(clk),
    .reset_n(reset_n),
    .load(reg_wr),
    .load_value(WRITE_DELAY_CYC),
    .expired(delay_done)
  );

  // hold the last write until the delay runs out
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_reg <= 1'b0;
      pend_data_reg <= 16'h0000;
      pend_addr_reg <= 8'h00;
    end else if (reg_wr) begin
      pend_reg <= 1'b1;
      pend_data_reg <= reg_wr_data;
      pend_addr_reg <= reg_addr;
    end else if (delay_done) begin
      pend_reg <= 1'b0;
    end
  end

  // ============================================
  // configuration register with self-clearing full reset
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      config_reg <= `SBMR_CFG_RESET;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (apply_config) begin
        if (pend_data_reg[`SBMR_CFG_RST_BIT]) begin
          config_reg <= `SBMR_CFG_RESET; // reset bit never stored
          restart_reg <= 1'b1;
        end else begin
          config_reg <= pend_data_reg & `SBMR_CFG_WMASK;
          restart_reg <= 1'b1; // a mode write re-arms triggered runs
        end
      end
    end
  end

  wire soft_reset = apply_config && pend_data_reg[`SBMR_CFG_RST_BIT];

  // ============================================
  // conversion timer
  sbmr_timer u_conv_timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(timer_load),
    .load_value(timer_value),
    .expired(conv_done)
  );

  // ============================================
  // sequencer: next state and timer loads
  always @* begin
    state_next = state_reg;
    timer_load = 1'b0;
    timer_value = conv_cycles(shunt_setting);
    case (state_reg)
      ST_IDLE: state_next = ST_IDLE; // waits for a launch below
      ST_SHUNT: begin
        if (conv_done) begin
          if (mode[1]) begin
            state_next = ST_BUS; // both: bus follows shunt
            timer_load = 1'b1;
            timer_value = conv_cycles(bus_setting);
          end else begin
            state_next = ST_MATH;
          end
        end
      end
      ST_BUS: begin
        if (conv_done)
          state_next = ST_MATH;
      end
      ST_MATH: begin
        if (math_done) begin
          if (mode[2] && mode_active(mode)) begin
            timer_load = 1'b1;
            if (mode[0]) begin
              state_next = ST_SHUNT;
            end else begin
              state_next = ST_BUS;
              timer_value = conv_cycles(bus_setting);
            end
          end else begin
            state_next = ST_IDLE; // single run over
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // a launch overrides any running cycle, so an abort relaunches at once unless the new mode is power-down or off
    if (launch) begin
      if (mode_active(mode)) begin
        timer_load = 1'b1;
        if (mode[0]) begin
          state_next = ST_SHUNT;
        end else begin
          state_next = ST_BUS;
          timer_value = conv_cycles(bus_setting);
        end
      end else begin
        state_next = ST_IDLE;
      end
    end
  end

  // sequencer state register
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next; // boot pulse launches the default mode
  end

  // first run after reset starts the default continuous mode
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      boot_reg <= 1'b1;
    else
      boot_reg <= 1'b0;
  end

  // ============================================
  // results: latched only at the end of a conversion
  sbmr_shunt_fmt u_shunt_fmt (
    .sample(shunt_sample),
    .gain(config_reg[`SBMR_CFG_GAIN_HI:`SBMR_CFG_GAIN_LO]),
    .word(shunt_word)
  );

  assign bus_fs = config_reg[`SBMR_CFG_RANGE_BIT] ? `SBMR_BUS_FS_32V : `SBMR_BUS_FS_16V;
  assign bus_clamped = (bus_sample > {1'b0, bus_fs}) ? bus_fs : bus_sample[12:0];

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shunt_result_reg <= `SBMR_RES_RESET;
      bus_value_reg <= 13'h0000;
    end else if (soft_reset) begin
      shunt_result_reg <= `SBMR_RES_RESET;
      bus_value_reg <= 13'h0000;
    end else begin
      if (state_reg == ST_SHUNT && conv_done)
        shunt_result_reg <= shunt_word; // held until next completion
      if (state_reg == ST_BUS && conv_done)
        bus_value_reg <= bus_clamped;
    end
  end

  // ============================================
  // ready and overflow flags
  wire ready_set = (state_reg == ST_MATH) && math_done;
  wire ready_clr = (restart_reg && mode_active(mode)) ||
                   (reg_rd && reg_addr == `SBMR_PTR_POWER);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end else if (soft_reset) begin
      ready_reg <= 1'b0;
      overflow_reg <= 1'b0;
    end else begin
      if (ready_set)
        ready_reg <= 1'b1; // set wins over clear
      else if (ready_clr)
        ready_reg <= 1'b0;
      if (ready_set)
        overflow_reg <= math_overflow;
    end
  end

  // ============================================
  // math start pulse and front end controls
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      math_start <= 1'b0;
      shunt_gain_stage <= 2'b11;
      bus_range_select <= 1'b1;
      converter_busy <= 1'b0;
    end else begin
      math_start <= (state_reg != ST_MATH) && (state_next == ST_MATH);
      shunt_gain_stage <= config_reg[`SBMR_CFG_GAIN_HI:`SBMR_CFG_GAIN_LO];
      bus_range_select <= config_reg[`SBMR_CFG_RANGE_BIT];
      converter_busy <= (state_next != ST_IDLE) || boot_reg;
    end
  end

  // ============================================
  // read path, answered one cycle after the strobe
  assign bus_word = {bus_value_reg, 1'b0, ready_reg, overflow_reg};

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rd_data <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SBMR_PTR_CONFIG: reg_rd_data <= config_reg;
        `SBMR_PTR_SHUNT: reg_rd_data <= shunt_result_reg;
        `SBMR_PTR_BUS: reg_rd_data <= bus_word;
        `SBMR_PTR_POWER: reg_rd_data <= power_value;
        `SBMR_PTR_CURRENT: reg_rd_data <= current_value;
        default: reg_rd_data <= 16'h0000;
      endcase
    end
  end
endmodule // sbmr_top
`default_nettype wire

// ===== test/sbmr_engine_model.sv
// behavioural multiplier engine answering math_start
`timescale 1ns/1ns
`default_nettype none
module sbmr_engine_model #(
  parameter int DLY = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control from bench and block
  input wire logic math_start,
  input wire logic ovf_cmd,
  input wire logic slow,
  // results
  output logic math_done,
  output logic math_overflow
);
  int cnt;
  // ==========
  // done pulse after a prompt or slow delay
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      math_done <= 1'b0;
      math_overflow <= 1'b0;
    end else begin
      math_done <= (cnt == 1);
      math_overflow <= (cnt == 1) ? ovf_cmd : ~math_overflow;
      if (math_start) cnt <= slow ? DLY * 4 : DLY;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule // sbmr_engine_model
`default_nettype wire

// ===== test/sbmr_top_monitor.sv
// port assertions for the measurement result block
`timescale 1ns/1ns
`default_nettype none
module sbmr_top_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rd_data,
  // engine and front end
  input wire logic [15:0] power_value,
  input wire logic [15:0] current_value,
  input wire logic math_start,
  input wire logic [1:0] shunt_gain_stage,
  input wire logic bus_range_select,
  input wire logic converter_busy
);
  // ==========
  // relations between ports
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_reset_vals: assert property (
    $rose(reset_n) |-> shunt_gain_stage == 2'b11 && bus_range_select)
    else $error("gain or range not at reset value");
  chk_start_pulse: assert property (math_start |=> !math_start)
    else $error("math start longer than one cycle");
  chk_start_busy: assert property (math_start |-> converter_busy)
    else $error("math start outside a measurement");
  chk_rd_hold: assert property (!reg_rd |=> $stable(reg_rd_data))
    else $error("read data moved without a read");
  chk_bus_unused: assert property (
    reg_rd && reg_addr == 8'h02 |=> reg_rd_data[2] == 1'b0)
    else $error("bus word bit 2 set");
  chk_pwr_pass: assert property (
    reg_rd && reg_addr == 8'h03 |=> reg_rd_data == $past(power_value))
    else $error("power word wrong");
  chk_cur_pass: assert property (
    reg_rd && reg_addr == 8'h04 |=> reg_rd_data == $past(current_value))
    else $error("current word wrong");
  chk_unmapped_zero: assert property (
    reg_rd && reg_addr > 8'h04 |=> reg_rd_data == 16'h0000)
    else $error("unmapped read not zero");
endmodule // sbmr_top_monitor
`default_nettype wire

// ===== test/tb_sbmr_top.sv
// self-checking bench for the measurement result block
`timescale 1ns/1ns
`default_nettype none
module tb_sbmr_top;
  localparam int CPU = 1;
  // ==========
  // stimulus and observed signals
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wr_data = 16'h0000;
  logic [16:0] shunt_sample = 17'h00000;
  logic [13:0] bus_sample = 14'h0000;
  logic [15:0] power_value = 16'h0000;
  logic [15:0] current_value = 16'h0000;
  logic ovf_cmd = 1'b0;
  logic slow = 1'b0;
  logic rd_pend = 1'b0;
  wire [15:0] reg_rd_data;
  wire [1:0] shunt_gain_stage;
  wire math_start, math_done, math_overflow, bus_range_select, converter_busy;
  logic [16:0] seed = 17'h10dff;
  logic [15:0] esh = 16'h0000;
  logic [12:0] eb = 13'h0000;
  logic eovf = 1'b0;
  logic [15:0] expq[$];
  logic [7:0] aq[$];
  int errors = 0;
  int tests_run = 0;
  int n;
  int tc[16] = '{84, 148, 276, 532, 84, 148, 276, 532, 532, 1060, 2130, 4260, 8510,
                 17020, 34050, 68100};
  int tab[8] = '{32002, -32002, 16001, -16001, 8001, -8001, 4001, -4001};
  sbmr_top #(.CYCLES_PER_US(CPU)) uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wr_data(reg_wr_data), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .shunt_sample(shunt_sample), .bus_sample(bus_sample), .power_value(power_value),
    .current_value(current_value), .math_done(math_done), .math_overflow(math_overflow),
    .math_start(math_start), .shunt_gain_stage(shunt_gain_stage),
    .bus_range_select(bus_range_select), .converter_busy(converter_busy));
  sbmr_engine_model #(.DLY(3)) model (.clk(clk), .reset_n(reset_n), .math_start(math_start),
    .ovf_cmd(ovf_cmd), .slow(slow), .math_done(math_done), .math_overflow(math_overflow));
  // ==========
  // clock, helpers and bus tasks
  initial forever #4 clk = ~clk;
  function automatic int rnd();
    seed = {seed[15:0], seed[16] ^ seed[13]};
    return int'($signed(seed));
  endfunction
  function automatic logic [15:0] fmt(input int v, input logic [1:0] g);
    int lim;
    lim = 4000 << g;
    if (v > lim) v = lim;
    if (v < -lim) v = -lim;
    return v[15:0];
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    @(negedge clk);
    reg_addr = 8'h00;
    reg_wr_data = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    aq.push_back(a);
    expq.push_back(e);
    @(negedge clk);
    reg_rd = 1'b0;
  endtask
  // one measurement cycle with its reads
  task automatic meas(input logic [2:0] m, input logic [1:0] g, input logic [3:0] bs,
                      input logic [3:0] ss, input int sh, input int bu, input bit pw);
    int t;
    int lim;
    int len;
    t = (m[0] ? tc[ss] : 0) + (m[1] ? tc[bs] : 0);
    lim = g[0] ? 8000 : 4000;
    if (m[0]) esh = fmt(sh, g);
    if (m[1]) eb = (bu > lim) ? lim[12:0] : bu[12:0];
    wr({2'b00, g[0], g, bs, ss, m});
    repeat (4 * CPU + 2) @(negedge clk); // write has landed
    // new inputs only after the old run is aborted, so it cannot latch them
    n = rnd();
    slow = n[0];
    ovf_cmd = n[1];
    power_value = n[15:0];
    current_value = ~n[15:0];
    shunt_sample = sh[16:0];
    bus_sample = bu[13:0];
    len = 0;
    while (math_start !== 1'b1 && len < 80000) begin
      @(negedge clk);
      len++;
    end
    check("conv time", {15'h0000, len >= t - 2 && len <= t + 4}, 16'h0001);
    check("front end", {13'h0000, bus_range_select, shunt_gain_stage}, {13'h0000, g[0], g});
    if (slow) rd(8'h02, {eb, 2'b00, eovf});
    repeat (30) @(negedge clk);
    eovf = ovf_cmd;
    rd(8'h01, esh);
    rd(8'h02, {eb, 2'b01, eovf});
    if (pw) begin
      rd(8'h03, power_value);
      rd(8'h04, current_value);
      rd(8'h02, {eb, 2'b00, eovf});
    end
    n = 0;
    repeat (300) @(negedge clk) n += converter_busy;
    check("busy after cycle", {15'h0000, n > 0}, {15'h0000, m[2]});
  endtask
  // ==========
  // read result checker
  always @(posedge clk) begin
    if (rd_pend) check($sformatf("reg %h", aq.pop_front()), reg_rd_data, expq.pop_front());
    rd_pend <= reg_rd;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (95000) @(posedge clk);
    errors++;
    finish_test();
  end
  // ==========
  // main sequence
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    rd(8'h00, 16'h399f);
    rd(8'h01, 16'h0000);
    rd(8'h02, 16'h0000);
    rd(8'h07, 16'h0000);
    $display("test reset values done");
    for (int g = 0; g < 4; g++)
      for (int i = 0; i < 9; i++)
        meas(3'b011, g[1:0], 4'h0, 4'h0, i < 8 ? tab[i] : rnd(), i[0] ? 4001 : 8001, 1);
    $display("test gain formats done");
    for (int m = 0; m < 8; m++) begin
      if (m % 4 == 0) begin
        meas(3'b011, 2'b11, 4'h0, 4'h0, rnd(), rnd() & 16383, 0);
        wr({13'h0700, m[2:0]});
        n = 0;
        repeat (600) @(negedge clk) n += converter_busy;
        check("busy when off", n[15:0], 16'h0000);
        rd(8'h02, {eb, 2'b01, eovf});
      end else begin
        meas(m[2:0], 2'b10, 4'h0, 4'h1, rnd(), rnd() & 16383, 1);
      end
    end
    $display("test modes done");
    for (int s = 0; s < 14; s++)
      meas(3'b011, 2'b01, s[3:0], s < 8 ? s[3:0] : 4'h0, rnd(), rnd() & 16383, 1);
    $display("test conversion times done");
    wr(16'h8000);
    repeat (10) @(negedge clk);
    rd(8'h00, 16'h399f);
    rd(8'h01, 16'h0000);
    rd(8'h02, 16'h0000);
    repeat (4) @(negedge clk);
    $display("test soft reset done");
    finish_test();
  end
endmodule // tb_sbmr_top
bind sbmr_top sbmr_top_monitor mon (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .power_value(power_value),
  .current_value(current_value), .math_start(math_start), .shunt_gain_stage(shunt_gain_stage),
  .bus_range_select(bus_range_select), .converter_busy(converter_busy));
`default_nettype wire
